// ===== core/ath_regs.sv
// Per-channel alarm hysteresis and threshold register bank.
// Assumes requests come from the serial command decoder on the same clock.
//
// Notes on behaviour
// - Each channel has one 8-bit read/write hysteresis register used by both its alarms.
// - The hysteresis byte is an unsigned band of plus or minus N LSB, zero meaning none.
// - The high threshold upper byte register supplies bits 15 to 8 of the high threshold.
// - The high threshold lower byte register supplies bits 7 to 0 of the high threshold.
// - Channel 0 hysteresis, upper and lower high threshold bytes sit at 15h, 16h and 17h.
// - Each channel holds a 40-bit setting in five consecutive byte registers.
`timescale 1ns/1ps
`default_nettype none

module ath_regs #(
  parameter int unsigned CHANNELS = ath_pkg::MAX_CHANNELS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire ath_pkg::ath_req_t req,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output ath_pkg::ath_setting_t settings [CHANNELS]
);

  localparam int unsigned NBYTES = CHANNELS * ath_pkg::BYTES_PER_CH;

  logic [7:0] byte_ff [NBYTES];
  logic [NBYTES-1:0] hit;
  logic rd_valid_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  ////////////////////////////////////////////////////////////////////////////

  for (genvar k = 0; k < NBYTES; k++) begin : g_byte
    localparam int unsigned POS = k % ath_pkg::BYTES_PER_CH;
    localparam int unsigned CH = k / ath_pkg::BYTES_PER_CH;
    localparam logic [7:0] RST = (POS == ath_pkg::HYST_POS) ?
        ath_pkg::HYST_RESET : (POS == ath_pkg::HT_UPPER_POS) ?
        ath_pkg::HT_UPPER_RESET : (POS == ath_pkg::HT_LOWER_POS) ?
        ath_pkg::HT_LOWER_RESET : (POS == ath_pkg::LT_UPPER_POS) ?
        ath_pkg::LT_UPPER_RESET : ath_pkg::LT_LOWER_RESET;
    localparam logic [6:0] ADDR = 7'(ath_pkg::HYST_CH0_OFFSET +
        CH * ath_pkg::CH_STRIDE + POS);

    assign hit[k] = (req.addr == ADDR);

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        byte_ff[k] <= RST;
      end else if (req.wr && hit[k]) begin
        byte_ff[k] <= req.wdata;
      end
    end

    // Every stored byte takes exactly the byte written to its own address.
    a_byte_write_take: assert property (
      @(posedge clk) disable iff (!reset_n)
      (req.wr && hit[k]) |=> byte_ff[k] == $past(req.wdata))
      else $error("A stored byte did not take its written value.");

    // A byte whose address is not written keeps its value.
    a_byte_hold_other: assert property (
      @(posedge clk) disable iff (!reset_n)
      !(req.wr && hit[k]) |=> $stable(byte_ff[k]))
      else $error("A stored byte changed without its own write.");
  end

  ////////////////////////////////////////////////////////////////////////////

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    localparam int unsigned B = c * ath_pkg::BYTES_PER_CH;
    assign settings[c].alarm_hysteresis_byte = byte_ff[B + ath_pkg::HYST_POS];
    assign settings[c].high_threshold = {byte_ff[B + ath_pkg::HT_UPPER_POS],
                                         byte_ff[B + ath_pkg::HT_LOWER_POS]};
    assign settings[c].low_threshold = {byte_ff[B + ath_pkg::LT_UPPER_POS],
                                        byte_ff[B + ath_pkg::LT_LOWER_POS]};
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_rd_data = ath_pkg::UNMAPPED_READ;
    for (int k = 0; k < NBYTES; k++) begin
      if (hit[k]) begin
        nxt_rd_data = byte_ff[k];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      rd_valid_ff <= req.rd;
      if (req.rd) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;

  ////////////////////////////////////////////////////////////////////////////

  a_hyst_write_ch0: assert property (
    @(posedge clk) disable iff (!reset_n)
    (req.wr && req.addr == 7'h15) |=>
      settings[0].alarm_hysteresis_byte == $past(req.wdata))
    else $error("Channel 0 hysteresis did not take the written byte.");

  a_hyst_band_held: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!req.wr) |=> $stable(settings[0].alarm_hysteresis_byte))
    else $error("Hysteresis changed without a write.");

  a_ht_upper_byte: assert property (
    @(posedge clk) disable iff (!reset_n)
    (req.wr && req.addr == 7'h16) |=>
      settings[0].high_threshold[15:8] == $past(req.wdata) &&
      $stable(settings[0].high_threshold[7:0]))
    else $error("High threshold upper byte not written alone.");

  a_ht_lower_byte: assert property (
    @(posedge clk) disable iff (!reset_n)
    (req.wr && req.addr == 7'h17) |=>
      settings[0].high_threshold[7:0] == $past(req.wdata) &&
      $stable(settings[0].high_threshold[15:8]))
    else $error("High threshold lower byte not written alone.");

  a_addr_ch0_decode: assert property (
    @(posedge clk) disable iff (!reset_n)
    (req.wr && req.addr == 7'h14) |=>
      $stable(settings[0].alarm_hysteresis_byte) &&
      $stable(settings[0].high_threshold))
    else $error("Write below 15h reached channel 0.");

  a_ch1_lt_lower: assert property (
    @(posedge clk) disable iff (!reset_n)
    (req.wr && req.addr == 7'h1E) |=>
      settings[1].low_threshold[7:0] == $past(req.wdata) &&
      $stable(settings[1].high_threshold))
    else $error("Channel 1 low threshold lower byte misplaced.");

  a_read_back: assert property (
    @(posedge clk) disable iff (!reset_n)
    (req.wr && req.addr == 7'h17) ##1 (req.rd && req.addr == 7'h17 &&
      !req.wr) |=> rd_valid && rd_data == $past(req.wdata, 2))
    else $error("Read did not return the last written byte.");

  a_read_unmapped: assert property (
    @(posedge clk) disable iff (!reset_n)
    (req.rd && req.addr == 7'h3F) |=> rd_valid && rd_data == 8'hFF)
    else $error("Unmapped read did not return all ones.");

  a_rd_valid_pulse: assert property (
    @(posedge clk) disable iff (!reset_n)
    req.rd |=> rd_valid)
    else $error("Read was not answered in the next cycle.");

  a_rd_valid_idle: assert property (
    @(posedge clk) disable iff (!reset_n)
    !req.rd |=> !rd_valid)
    else $error("Read answer stood without a read.");

  a_rd_data_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    !req.rd |=> $stable(rd_data))
    else $error("Read data changed without a read.");

  a_lt_upper_apart: assert property (
    @(posedge clk) disable iff (!reset_n)
    (req.wr && req.addr == 7'h18) |=>
      $stable(settings[0].alarm_hysteresis_byte) &&
      $stable(settings[0].high_threshold) &&
      settings[0].low_threshold[15:8] == $past(req.wdata))
    else $error("Channel 0 low threshold upper byte misplaced.");

  ////////////////////////////////////////////////////////////////////////////

  // The last channel only exists on the full eight-channel bank.
  if (CHANNELS == 8) begin : g_ch7_chk
    a_hyst_ch7_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      (req.wr && req.addr == 7'h38) |=>
        settings[7].alarm_hysteresis_byte == $past(req.wdata))
      else $error("Channel 7 hysteresis did not take the written byte.");

    a_ht_lower_ch7: assert property (
      @(posedge clk) disable iff (!reset_n)
      (req.wr && req.addr == 7'h3A) |=>
        settings[7].high_threshold[7:0] == $past(req.wdata) &&
        $stable(settings[7].high_threshold[15:8]))
      else $error("Channel 7 high threshold lower byte misplaced.");

    a_ht_upper_ch7: assert property (
      @(posedge clk) disable iff (!reset_n)
      (req.wr && req.addr == 7'h39) |=>
        settings[7].high_threshold[15:8] == $past(req.wdata) &&
        $stable(settings[7].high_threshold[7:0]))
      else $error("Channel 7 high threshold upper byte misplaced.");
  end

endmodule // ath_regs

`default_nettype wire

// ===== core/ath_pkg.sv
// Package for the per-channel alarm setting register bank.
// Assumes a byte-wide register port on the device clock.
package ath_pkg;

  localparam int unsigned MAX_CHANNELS = 8;
  localparam int unsigned BYTES_PER_CH = 5;
  localparam int unsigned ADDR_W = 7;

  // Channel 0 register addresses; later channels follow at a stride of five.
  localparam logic [6:0] HYST_CH0_OFFSET = 7'h15;
  localparam logic [6:0] HT_UPPER_CH0_OFFSET = 7'h16;
  localparam logic [6:0] HT_LOWER_CH0_OFFSET = 7'h17;
  localparam logic [6:0] LT_UPPER_CH0_OFFSET = 7'h18;
  localparam logic [6:0] LT_LOWER_CH0_OFFSET = 7'h19;
  localparam logic [6:0] CH_STRIDE = 7'h05;

  // Byte positions inside one channel's group.
  localparam int unsigned HYST_POS = 0;
  localparam int unsigned HT_UPPER_POS = 1;
  localparam int unsigned HT_LOWER_POS = 2;
  localparam int unsigned LT_UPPER_POS = 3;
  localparam int unsigned LT_LOWER_POS = 4;

  localparam logic [7:0] HYST_RESET = 8'h00;
  localparam logic [7:0] HT_UPPER_RESET = 8'h01;
  localparam logic [7:0] HT_LOWER_RESET = 8'h01;
  localparam logic [7:0] LT_UPPER_RESET = 8'h00;
  localparam logic [7:0] LT_LOWER_RESET = 8'h00;

  // Value returned for an address that holds no register.
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ath_req_t;

  typedef struct packed {
    logic [7:0] alarm_hysteresis_byte;
    logic [15:0] high_threshold;
    logic [15:0] low_threshold;
  } ath_setting_t;

endpackage

// ===== tb/ath_host.sv
// Host model that presents register requests to the bank.
// Assumes calls are made at a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ath_host (
  input wire logic clk,
  output ath_pkg::ath_req_t req
);
  initial req = '0;
  task automatic access(input logic w, input logic [6:0] a,
    input logic [7:0] d);
    req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk);
  endtask
  task automatic idle;
    req <= '0;
    @(posedge clk);
  endtask
endmodule // ath_host
`default_nettype wire

// ===== tb/alarm_threshold_hyst_regs_bench.sv
// Bench for the alarm setting register bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`default_nettype none
module alarm_threshold_hyst_regs_bench;
  typedef struct {logic [6:0] a; logic [7:0] d;} ath_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  ath_pkg::ath_req_t req;
  logic rd_valid;
  logic [7:0] rd_data;
  ath_pkg::ath_setting_t settings [8];
  ath_pkg::ath_setting_t rst_set = {8'h00, 16'h0101, 16'h0000};
  ath_pkg::ath_setting_t exp_set [8];
  int errors = 0;
  int n_tests = 0;
  ath_row_t rows [9] = '{'{7'h15, 8'hFF}, '{7'h16, 8'hAA},
    '{7'h17, 8'hFF}, '{7'h26, 8'h5A}, '{7'h38, 8'h81}, '{7'h3A, 8'h3C},
    '{7'h1D, 8'hC3}, '{7'h1E, 8'h96}, '{7'h18, 8'h42}};
  always #12.5 clk = ~clk;
  ath_regs #(.CHANNELS(8)) i_dut (.clk(clk), .reset_n(reset_n),
    .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .settings(settings));
  ath_host i_host (.clk(clk), .req(req));
  task automatic check(input string name, input logic [39:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    i_host.access(1'b0, a, 8'h00);
    fork
      i_host.idle();
      begin
        #1 check("rd_valid", rd_valid, 1);
      end
    join
    #1 check("rd_data", rd_data, exp);
    check("rd_valid low", rd_valid, 0);
  endtask
  task automatic all_chk;
    for (int c = 0; c < 8; c++) begin
      check("settings", settings[c], exp_set[c]);
    end
  endtask
  initial begin
    int c;
    foreach (exp_set[k]) exp_set[k] = rst_set;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    #1 all_chk();
    check("rd_data init", rd_data, 8'h00);
    @(posedge clk);
    rd_chk(7'h16, ath_pkg::HT_UPPER_RESET);
    for (int i = 0; i < 9; i++) begin
      c = (int'(rows[i].a) - 'h15) / 5;
      case ((int'(rows[i].a) - 'h15) % 5)
        0: exp_set[c].alarm_hysteresis_byte = rows[i].d;
        1: exp_set[c].high_threshold[15:8] = rows[i].d;
        3: exp_set[c].low_threshold[15:8] = rows[i].d;
        4: exp_set[c].low_threshold[7:0] = rows[i].d;
        default: exp_set[c].high_threshold[7:0] = rows[i].d;
      endcase
      @(posedge clk);
      i_host.access(1'b1, rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].d);
      all_chk();
    end
    @(posedge clk);
    i_host.access(1'b1, 7'h14, 8'h5C);
    rd_chk(7'h3F, ath_pkg::UNMAPPED_READ);
    all_chk();
    @(posedge clk);
    i_host.access(1'b1, 7'h3D, 8'h77);
    rd_chk(7'h3D, ath_pkg::UNMAPPED_READ);
    all_chk();
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    foreach (exp_set[k]) exp_set[k] = rst_set;
    all_chk();
    check("rd_data reset", rd_data, 8'h00);
    reset_n <= 1'b1;
    @(posedge clk);
    #1 check("rd_valid reset", rd_valid, 0);
    all_chk();
    @(posedge clk);
    rd_chk(7'h17, ath_pkg::HT_LOWER_RESET);
    report_and_stop();
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule // alarm_threshold_hyst_regs_bench
`default_nettype wire
